//--- eds_top.sv
// Contract
// RL1 - Transmit word bit 27 is the OR of transmit status bits 26 to 0.
// RL2 - Transmit bit 27 one means error during send, zero means clean.
// RL3 - Transmit abort bit 8 is set when any of bits 4 to 0 is set.
// RL4 - A set transmit abort bit also sets transmit bit 27.
// RL5 - Receive word bit 27 is set when any receive status bit is set.
// RL6 - Receive error summary starts at zero until an error is recorded.
// RL7 - Copy-enable setting decides whether multicast joins receive status.
// RL8 - Receive bit 9 reports a receive FIFO overflow for the frame.
// RL9 - Receive abort bit 8 is OR of bits 9, 7 and 4 to 0.
// RL10 - A set receive abort bit also sets receive bit 27.
// RL11 - Receive bit 7 reports a multicast destination address.
// RL12 - Receive bit 5 reports discard request in full variant only.
// RL13 - Receive bit 4 reports a residual non-octet bit count.
// RL14 - Receive bit 3 reports a frame longer than the maximum.
// RL15 - Receive bit 2 reports a frame shorter than the minimum.
// RL16 - Receive bit 1 reports a transceiver receive error.
// RL17 - Receive bit 0 reports a wrong frame check sequence.
// RL18 - Copy-enable resets to zero; one suppresses multicast bit 7.
// RL19 - Receive descriptor: status, lengths, buffer address, then padding.
// RL20 - Reserved status positions are written as zero.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module eds_top
   import eds_pkg::*;
#(
   parameter int   ADDR_W       = 12,
   parameter logic FULL_VARIANT = 1'b1
)
(
   input  wire logic              clock_i,
   input  wire logic              rst_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   input  wire logic              tx_done_i,
   input  wire logic [4:0]        tx_err_i,
   input  wire logic              rx_done_i,
   input  wire logic              rx_overflow_i,
   input  wire logic              rx_multicast_i,
   input  wire logic              rx_discard_i,
   input  wire logic              rx_residual_i,
   input  wire logic              rx_too_long_i,
   input  wire logic              rx_too_short_i,
   input  wire logic              rx_phy_err_i,
   input  wire logic              rx_crc_err_i,
   input  wire logic [1:0]        rx_frame_pos_i,
   input  wire logic              rx_last_desc_i,
   input  wire logic [15:0]       rx_data_len_i,
   input  wire logic [31:0]       rx_buf_addr_i,
   output logic                   tx_wb_valid_o,
   output logic      [31:0]       tx_desc_word0_o,
   output logic                   rx_wb_valid_o,
   output logic      [31:0]       rx_desc_word0_o,
   output logic      [31:0]       rx_desc_word1_o,
   output logic      [31:0]       rx_desc_word2_o
);

   // ---------------------------------------------------------------
   // Status composers
   // ---------------------------------------------------------------
   eds_stat_if st ();

   logic               mce_ff;
   logic               nxt_mce;
   logic [RX_LEN_W-1:0] buflen_ff;
   logic [RX_LEN_W-1:0] nxt_buflen;

   assign st.tx_done = tx_done_i;
   assign st.tx_err  = tx_err_i;
   assign st.rx_done = rx_done_i;
   assign st.rx_ev   = {rx_overflow_i, 1'b0, rx_multicast_i, 1'b0,
                        rx_discard_i, rx_residual_i, rx_too_long_i,
                        rx_too_short_i, rx_phy_err_i, rx_crc_err_i};
   assign st.rx_mce  = mce_ff;
   assign st.rx_full = FULL_VARIANT;
   assign st.rx_pos  = rx_frame_pos_i;
   assign st.rx_last = rx_last_desc_i;

   eds_tx_status u_tx (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .st      (st.txc)
   );

   eds_rx_status u_rx (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .st      (st.rxc)
   );

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic        pready_ff;
   logic        nxt_pready;
   logic        pslverr_ff;
   logic        nxt_pslverr;
   logic        setup;
   logic        access;
   logic        hit;
   logic [31:0] rd_word;

   // Every access gets exactly one wait-free access cycle; the read
   // word is captured in the setup cycle so it is stable while ready.
   always_comb begin
      setup   = psel_i & ~penable_i;
      access  = psel_i & penable_i & pready_ff;
      hit     = 1'b1;
      rd_word = WORD_RST;
      unique case (paddr_i)
         OFS_CTRL:      rd_word[CTRL_MCE_BIT] = mce_ff;
         OFS_TX_LAST:   rd_word = tx_desc_word0_o;
         OFS_RX_LAST:   rd_word = rx_desc_word0_o;
         OFS_RX_BUFLEN: rd_word[RX_LEN_W-1:0] = buflen_ff;
         default:       hit = 1'b0;
      endcase
      nxt_pready  = setup;
      nxt_pslverr = setup & ~hit;
      nxt_prdata  = (setup & ~pwrite_i) ? rd_word : WORD_RST;
      nxt_mce     = mce_ff;
      nxt_buflen  = buflen_ff;
      if (access & pwrite_i & ~pslverr_ff) begin
         if (paddr_i == OFS_CTRL) begin
            nxt_mce = pwdata_i[CTRL_MCE_BIT];                 // RL18
         end
         if (paddr_i == OFS_RX_BUFLEN) begin
            nxt_buflen = pwdata_i[RX_LEN_W-1:0];
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         prdata_ff  <= WORD_RST;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         mce_ff     <= CTRL_MCE_RST;                          // RL18
         buflen_ff  <= RX_BUFLEN_RST;
      end else begin
         prdata_ff  <= nxt_prdata;
         pready_ff  <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         mce_ff     <= nxt_mce;
         buflen_ff  <= nxt_buflen;
      end
   end

   assign prdata_o  = prdata_ff;
   assign pready_o  = pready_ff;
   assign pslverr_o = pslverr_ff;

   // ---------------------------------------------------------------
   // Descriptor write-back
   // ---------------------------------------------------------------
   logic        tx_val_ff;
   logic        nxt_tx_val;
   logic [31:0] tx_w0_ff;
   logic [31:0] nxt_tx_w0;
   logic        rx_val_ff;
   logic        nxt_rx_val;
   logic [31:0] rx_w0_ff;
   logic [31:0] nxt_rx_w0;
   logic [31:0] rx_w1_ff;
   logic [31:0] nxt_rx_w1;
   logic [31:0] rx_w2_ff;
   logic [31:0] nxt_rx_w2;

   // Words hold their last value between frames so software can read
   // the most recent status back.
   always_comb begin
      nxt_tx_val = tx_done_i;
      nxt_tx_w0  = tx_done_i ? st.tx_word : tx_w0_ff;         // RL1
      nxt_rx_val = rx_done_i;
      nxt_rx_w0  = rx_done_i ? st.rx_word : rx_w0_ff;         // RL5
      nxt_rx_w1  = rx_done_i ? {buflen_ff, rx_data_len_i} : rx_w1_ff; // RL19
      nxt_rx_w2  = rx_done_i ? rx_buf_addr_i : rx_w2_ff;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         tx_val_ff <= 1'b0;
         tx_w0_ff  <= WORD_RST;
         rx_val_ff <= 1'b0;
         rx_w0_ff  <= WORD_RST;                               // RL6
         rx_w1_ff  <= WORD_RST;
         rx_w2_ff  <= WORD_RST;
      end else begin
         tx_val_ff <= nxt_tx_val;
         tx_w0_ff  <= nxt_tx_w0;
         rx_val_ff <= nxt_rx_val;
         rx_w0_ff  <= nxt_rx_w0;
         rx_w1_ff  <= nxt_rx_w1;
         rx_w2_ff  <= nxt_rx_w2;
      end
   end

   assign tx_wb_valid_o   = tx_val_ff;
   assign tx_desc_word0_o = tx_w0_ff;
   assign rx_wb_valid_o   = rx_val_ff;
   assign rx_desc_word0_o = rx_w0_ff;
   assign rx_desc_word1_o = rx_w1_ff;
   assign rx_desc_word2_o = rx_w2_ff;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence s_rx_end_ovf;
      rx_overflow_i && rx_done_i;
   endsequence

   sequence s_rx_end_mcast;
      rx_multicast_i && rx_done_i && !mce_ff;
   endsequence

   sequence s_tx_err_then_end;
      (tx_err_i != 5'h00) && !tx_done_i ##1 !tx_done_i [*2] ##1 tx_done_i;
   endsequence

   chk_apb_one_wait: assert property (setup |=> pready_o ##1 !pready_o)
      else $error("APB ready not exactly one cycle after setup");
   chk_mce_write: assert property (  // RL18
      access && pwrite_i && !pslverr_o && paddr_i == OFS_CTRL
      |=> mce_ff == $past(pwdata_i[CTRL_MCE_BIT]))
      else $error("copy enable not updated by write");
   chk_mce_reset: assert property ($past(rst_i) |-> !mce_ff) // RL18
      else $error("copy enable not zero after reset");
   chk_tx_summary: assert property ( // RL1
      tx_wb_valid_o |-> tx_desc_word0_o[TX_SUM_BIT]
                        == |tx_desc_word0_o[TX_SUM_BIT-1:0])
      else $error("tx summary bit wrong");
   chk_tx_abort_sum: assert property ( // RL3
      tx_wb_valid_o |-> tx_desc_word0_o[TX_ABORT_BIT]
         == |tx_desc_word0_o[4:0]
         && (!tx_desc_word0_o[TX_ABORT_BIT] || tx_desc_word0_o[TX_SUM_BIT]))
      else $error("tx abort bit wrong");
   chk_tx_err_kept: assert property ( // RL2
      s_tx_err_then_end |=> tx_wb_valid_o && tx_desc_word0_o[TX_SUM_BIT])
      else $error("earlier tx error lost at frame end");
   chk_tx_reserved: assert property ( // RL20
      tx_wb_valid_o |-> tx_desc_word0_o[26:9] == 18'h00000
                        && tx_desc_word0_o[7:5] == 3'h0)
      else $error("tx reserved bits not zero");
   chk_rx_summary: assert property ( // RL5
      rx_wb_valid_o |-> rx_desc_word0_o[RX_SUM_BIT]
                        == |rx_desc_word0_o[RX_SUM_BIT-1:0])
      else $error("rx summary bit wrong");
   chk_rx_abort_sum: assert property ( // RL9
      rx_wb_valid_o |-> rx_desc_word0_o[RX_ABORT_BIT]
         == (rx_desc_word0_o[9] | rx_desc_word0_o[7]
             | (|rx_desc_word0_o[4:0]))
         && (!rx_desc_word0_o[RX_ABORT_BIT] || rx_desc_word0_o[RX_SUM_BIT]))
      else $error("rx abort bit wrong");
   chk_rx_reserved: assert property ( // RL20
      rx_wb_valid_o |-> rx_desc_word0_o[26:10] == 17'h00000
         && !rx_desc_word0_o[RX_RSV6_BIT] && !rx_desc_word0_o[31]
         && (FULL_VARIANT || !rx_desc_word0_o[RX_DISC_BIT]))
      else $error("rx reserved bits not zero");
   chk_rx_init_clear: assert property ( // RL6
      $past(rst_i) |-> !rx_desc_word0_o[RX_SUM_BIT] && !rx_wb_valid_o)
      else $error("rx summary not clear after reset");
   chk_rx_mcast_gate: assert property ( // RL7
      rx_wb_valid_o && mce_ff && $past(mce_ff) && $past(mce_ff, 2)
      && $past(rx_done_i, 2) |-> !rx_desc_word0_o[RX_MCAST_BIT])
      else $error("multicast shown while suppressed");
   chk_rx_mcast_copy: assert property ( // RL11
      s_rx_end_mcast |=> rx_wb_valid_o && rx_desc_word0_o[RX_MCAST_BIT]
                         && rx_desc_word0_o[RX_SUM_BIT])
      else $error("multicast not shown");
   chk_rx_ovf_copy: assert property ( // RL8
      s_rx_end_ovf |=> rx_desc_word0_o[RX_OVF_BIT]
                       && rx_desc_word0_o[RX_ABORT_BIT])
      else $error("overflow not shown");
   chk_rx_disc_copy: assert property ( // RL12
      rx_discard_i && rx_done_i |=> rx_desc_word0_o[RX_DISC_BIT]
                                    == FULL_VARIANT)
      else $error("discard bit wrong");
   chk_rx_resid_copy: assert property ( // RL13
      rx_residual_i && rx_done_i |=> rx_desc_word0_o[RX_RESID_BIT])
      else $error("residual bit not shown");
   chk_rx_long_copy: assert property ( // RL14
      rx_too_long_i && rx_done_i |=> rx_desc_word0_o[RX_LONG_BIT])
      else $error("too long bit not shown");
   chk_rx_short_copy: assert property ( // RL15
      rx_too_short_i && rx_done_i |=> rx_desc_word0_o[RX_SHORT_BIT])
      else $error("too short bit not shown");
   chk_rx_phy_copy: assert property ( // RL16
      rx_phy_err_i && rx_done_i |=> rx_desc_word0_o[RX_PHY_BIT])
      else $error("transceiver error bit not shown");
   chk_rx_crc_copy: assert property ( // RL17
      rx_crc_err_i && rx_done_i |=> rx_desc_word0_o[RX_CRC_BIT])
      else $error("crc bit not shown");
   chk_rx_word1_layout: assert property ( // RL19
      rx_done_i |=> rx_desc_word1_o == {$past(buflen_ff),
                                        $past(rx_data_len_i)})
      else $error("rx length word wrong");

endmodule : eds_top

//--- eds_pkg.sv
package eds_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [11:0] OFS_CTRL      = 12'h000;
   localparam logic [11:0] OFS_TX_LAST   = 12'h004;
   localparam logic [11:0] OFS_RX_LAST   = 12'h008;
   localparam logic [11:0] OFS_RX_BUFLEN = 12'h00C;

   localparam int          CTRL_MCE_BIT   = 7;
   localparam logic        CTRL_MCE_RST   = 1'b0;
   localparam logic [15:0] RX_BUFLEN_RST  = 16'h0000;
   localparam logic [31:0] WORD_RST       = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Transmit status word layout
   // ---------------------------------------------------------------
   localparam int TX_ERR_W     = 5;
   localparam int TX_ABORT_BIT = 8;
   localparam int TX_SUM_BIT   = 27;

   // ---------------------------------------------------------------
   // Receive status word layout
   // ---------------------------------------------------------------
   localparam int RX_EV_W      = 10;
   localparam int RX_CRC_BIT   = 0;
   localparam int RX_PHY_BIT   = 1;
   localparam int RX_SHORT_BIT = 2;
   localparam int RX_LONG_BIT  = 3;
   localparam int RX_RESID_BIT = 4;
   localparam int RX_DISC_BIT  = 5;
   localparam int RX_RSV6_BIT  = 6;
   localparam int RX_MCAST_BIT = 7;
   localparam int RX_ABORT_BIT = 8;
   localparam int RX_OVF_BIT   = 9;
   localparam int RX_SUM_BIT   = 27;
   localparam int RX_FP0_BIT   = 28;
   localparam int RX_FP1_BIT   = 29;
   localparam int RX_LAST_BIT  = 30;
   localparam int RX_LEN_W     = 16;

endpackage : eds_pkg

//--- eds_stat_if.sv
`timescale 1ns/10ps
interface eds_stat_if;
   logic        tx_done;
   logic [4:0]  tx_err;
   logic [31:0] tx_word;
   logic        rx_done;
   logic [9:0]  rx_ev;
   logic        rx_mce;
   logic        rx_full;
   logic [1:0]  rx_pos;
   logic        rx_last;
   logic [31:0] rx_word;

   modport txc (input tx_done, tx_err, output tx_word);
   modport rxc (input rx_done, rx_ev, rx_mce, rx_full, rx_pos, rx_last,
                output rx_word);
endinterface : eds_stat_if

//--- eds_tx_status.sv
`timescale 1ns/10ps
module eds_tx_status
   import eds_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   eds_stat_if.txc  st
);

   logic [TX_ERR_W-1:0] acc_ff;
   logic [TX_ERR_W-1:0] nxt_acc;
   logic [TX_ERR_W-1:0] seen;
   logic [31:0]         word;

   // Errors seen in the ending cycle still belong to this frame.
   always_comb begin
      seen    = acc_ff | st.tx_err;
      nxt_acc = st.tx_done ? '0 : seen;
      word    = WORD_RST;                                    // RL20
      word[TX_ERR_W-1:0] = seen;
      word[TX_ABORT_BIT] = |seen;                            // RL3
      word[TX_SUM_BIT]   = |word[TX_SUM_BIT-1:0];            // RL1 RL2 RL4
      st.tx_word = word;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         acc_ff <= '0;
      end else begin
         acc_ff <= nxt_acc;
      end
   end

endmodule : eds_tx_status

//--- eds_rx_status.sv
`timescale 1ns/10ps
module eds_rx_status
   import eds_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   eds_stat_if.rxc  st
);

   logic [RX_EV_W-1:0] acc_ff;
   logic [RX_EV_W-1:0] nxt_acc;
   logic [RX_EV_W-1:0] ev;
   logic [RX_EV_W-1:0] seen;
   logic [31:0]        word;

   // Masking happens before accumulation, so a suppressed multicast
   // indication never reaches the abort or summary bits.
   always_comb begin
      ev = st.rx_ev;
      ev[RX_MCAST_BIT] = st.rx_ev[RX_MCAST_BIT] & ~st.rx_mce; // RL7 RL18
      ev[RX_DISC_BIT]  = st.rx_ev[RX_DISC_BIT] & st.rx_full;  // RL12
      ev[RX_RSV6_BIT]  = 1'b0;                                // RL20
      ev[RX_ABORT_BIT] = 1'b0;
      seen    = acc_ff | ev;
      nxt_acc = st.rx_done ? '0 : seen;
      word    = WORD_RST;                                     // RL20
      word[RX_EV_W-1:0] = seen;                 // RL8 RL11 RL13 RL14 RL15
      word[RX_ABORT_BIT] = seen[RX_OVF_BIT] | seen[RX_MCAST_BIT]
                         | (|seen[RX_RESID_BIT:RX_CRC_BIT]);  // RL9
      word[RX_SUM_BIT]  = |word[RX_SUM_BIT-1:0];              // RL5 RL10
      word[RX_FP0_BIT]  = st.rx_pos[0];                       // RL19
      word[RX_FP1_BIT]  = st.rx_pos[1];
      word[RX_LAST_BIT] = st.rx_last;
      st.rx_word = word;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         acc_ff <= '0;
      end else begin
         acc_ff <= nxt_acc;                                   // RL16 RL17
      end
   end

endmodule : eds_rx_status

//--- eds_desc_mem.sv
`timescale 1ns/10ps
module eds_desc_mem (
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire logic        tx_valid_i,
   input  wire logic [31:0] tx_word0_i,
   input  wire logic        rx_valid_i,
   input  wire logic [31:0] rx_word0_i,
   input  wire logic [31:0] rx_word1_i,
   input  wire logic [31:0] rx_word2_i,
   output logic             tx_seen_o,
   output logic [31:0]      tx_word0_o,
   output logic             rx_seen_o,
   output logic [95:0]      rx_desc_o
);
   // ---------------------------------------------------------------
   // Descriptor memory
   // ---------------------------------------------------------------
   // The fourth receive word is padding that the device never writes,
   // so it is not held here.
   logic [31:0] tx_mem_ff;
   logic [31:0] rx_mem_ff [3];
   logic        tx_seen_ff;
   logic        rx_seen_ff;

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         tx_seen_ff   <= 1'b0;
         rx_seen_ff   <= 1'b0;
         tx_mem_ff    <= 32'h0000_0000;
      end else begin
         tx_seen_ff <= tx_valid_i;
         rx_seen_ff <= rx_valid_i;
         if (tx_valid_i) begin
            tx_mem_ff <= tx_word0_i;
         end
         if (rx_valid_i) begin
            rx_mem_ff[0] <= rx_word0_i;
            rx_mem_ff[1] <= rx_word1_i;
            rx_mem_ff[2] <= rx_word2_i;
         end
      end
   end

   assign tx_seen_o  = tx_seen_ff;
   assign tx_word0_o = tx_mem_ff;
   assign rx_seen_o  = rx_seen_ff;
   assign rx_desc_o  = {rx_mem_ff[0], rx_mem_ff[1], rx_mem_ff[2]};
endmodule : eds_desc_mem

//--- testbench.sv
`timescale 1ns/10ps
module testbench;
   import eds_pkg::*;
   logic        clock_i, rst_i, psel, penable, pwrite, pready, pslverr;
   logic        tx_done, rx_done, rx_last, tx_v, rx_v, m_txs, m_rxs, mce;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, tx_w0, rx_w0, rx_w1, rx_w2, m_tx, q;
   logic [31:0] rx_addr, last_rx;
   logic [4:0]  tx_err;
   logic [9:0]  ev;
   logic [1:0]  rx_pos;
   logic [15:0] rx_len, buflen;
   logic [95:0] m_rx;
   logic [95:0] txq[$];
   logic [95:0] rxq[$];
   logic        e;
   int          err_total, checks, seed;

   eds_top dut (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .tx_done_i(tx_done), .tx_err_i(tx_err),
      .rx_done_i(rx_done), .rx_overflow_i(ev[9]), .rx_multicast_i(ev[7]),
      .rx_discard_i(ev[5]), .rx_residual_i(ev[4]), .rx_too_long_i(ev[3]),
      .rx_too_short_i(ev[2]), .rx_phy_err_i(ev[1]), .rx_crc_err_i(ev[0]),
      .rx_frame_pos_i(rx_pos), .rx_last_desc_i(rx_last),
      .rx_data_len_i(rx_len), .rx_buf_addr_i(rx_addr),
      .tx_wb_valid_o(tx_v), .tx_desc_word0_o(tx_w0), .rx_wb_valid_o(rx_v),
      .rx_desc_word0_o(rx_w0), .rx_desc_word1_o(rx_w1),
      .rx_desc_word2_o(rx_w2));

   eds_desc_mem mem (.clock_i(clock_i), .rst_i(rst_i), .tx_valid_i(tx_v),
      .tx_word0_i(tx_w0), .rx_valid_i(rx_v), .rx_word0_i(rx_w0),
      .rx_word1_i(rx_w1), .rx_word2_i(rx_w2), .tx_seen_o(m_txs),
      .tx_word0_o(m_tx), .rx_seen_o(m_rxs), .rx_desc_o(m_rx));

   initial begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end

   // ---------------------------------------------------------------
   // Checking and closing
   // ---------------------------------------------------------------
   task automatic cmp(input string nm, input logic [95:0] x,
                      input logic [95:0] g);
      checks++;
      if (g !== x) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, x, g);
      end
   endtask : cmp

   task automatic end_of_test;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clock_i);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_total++;
         end_of_test();
      end
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic logic [31:0] exp_tx(input logic [4:0] t);
      logic [31:0] w;
      w = WORD_RST;
      w[4:0] = t;
      w[TX_ABORT_BIT] = |t;
      w[TX_SUM_BIT] = |w[26:0];
      return w;
   endfunction : exp_tx

   function automatic logic [31:0] exp_rx(input logic [9:0] v,
      input logic m, input logic [1:0] p, input logic l);
      logic [31:0] w;
      w = WORD_RST;
      w[9:0] = v & 10'h2BF;
      if (m) w[RX_MCAST_BIT] = 1'b0;
      w[RX_ABORT_BIT] = w[9] | w[7] | (|w[4:0]);
      w[RX_SUM_BIT] = |w[26:0];
      w[RX_FP1_BIT:RX_FP0_BIT] = p;
      w[RX_LAST_BIT] = l;
      return w;
   endfunction : exp_rx

   // A non-zero pre value is raised three cycles ahead of the done cycle.
   task automatic tx_frame(input logic [4:0] pre, input logic [4:0] t);
      if (pre != 5'h00) begin
         @(posedge clock_i);
         tx_err  <= pre;
         tx_done <= 1'b0;
         repeat (2) begin
            @(posedge clock_i);
            tx_err <= 5'h00;
         end
      end
      @(posedge clock_i);
      tx_err  <= t;
      tx_done <= 1'b1;
      txq.push_back({64'h0, exp_tx(pre | t)});
   endtask : tx_frame

   // A non-zero pre value is raised one cycle ahead of the done cycle.
   task automatic rx_frame(input logic [9:0] pre, input logic [9:0] at);
      logic [31:0] r;
      if (pre != 10'h000) begin
         @(posedge clock_i);
         ev      <= pre;
         rx_done <= 1'b0;
      end
      r = $random(seed);
      @(posedge clock_i);
      ev      <= at;
      rx_done <= 1'b1;
      rx_pos  <= r[1:0];
      rx_last <= r[2];
      rx_len  <= r[31:16];
      rx_addr <= ~r;
      last_rx = exp_rx(pre | at, mce, r[1:0], r[2]);
      rxq.push_back({last_rx, buflen, r[31:16], ~r});
   endtask : rx_frame

   task automatic idle;
      @(posedge clock_i);
      tx_done <= 1'b0;
      rx_done <= 1'b0;
      tx_err  <= 5'h00;
      ev      <= 10'h000;
   endtask : idle

   always @(posedge clock_i) begin
      if (m_txs) begin
         cmp("tx_word0", (txq.size() > 0) ? txq.pop_front() : 'x,
             m_tx);
      end
      if (m_rxs) begin
         cmp("rx_desc", (rxq.size() > 0) ? rxq.pop_front() : 'x,
             m_rx);
      end
   end

   initial begin
      repeat (20000) @(posedge clock_i);
      err_total++;
      end_of_test();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      seed = 38865;
      err_total = 0;
      checks = 0;
      mce = 1'b0;
      {rst_i, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
      {tx_done, tx_err, rx_done, ev, rx_pos, rx_last} = 20'h0;
      {rx_len, rx_addr} = 48'h0;
      repeat (10) @(posedge clock_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 12'h004 * i[11:0], 32'h0000_0000);
         cmp("reset_read", 32'h0000_0000, q);
         cmp("read_err", (i == 4), e);
      end
      buflen = 16'($random(seed));
      apb(1'b1, OFS_RX_BUFLEN, {16'h0000, buflen});
      apb(1'b1, 12'h010, 32'hFFFF_FFFF);
      cmp("unmapped_err", 1'b1, e);
      tx_frame(5'h05, 5'h00);
      for (int i = 0; i < 32; i++) tx_frame(5'h00, i[4:0]);
      idle();
      apb(1'b0, OFS_TX_LAST, 32'h0000_0000);
      cmp("tx_last", exp_tx(5'h1F), q);
      for (int m = 0; m < 2; m++) begin
         mce = m[0];
         apb(1'b1, OFS_CTRL, {32{m[0]}});
         apb(1'b0, OFS_CTRL, 32'h0000_0000);
         cmp("ctrl", {24'h0, m[0], 7'h00}, q);
         for (int b = 0; b < 10; b++) rx_frame(10'h000, 10'h001 << b);
         rx_frame(10'h080, 10'h000);
         rx_frame(10'h001, 10'h000);
         repeat (20) rx_frame(10'($random(seed)), 10'($random(seed)));
         idle();
         apb(1'b0, OFS_RX_LAST, 32'h0000_0000);
         cmp("rx_last", last_rx, q);
      end
      repeat (5) @(posedge clock_i);
      cmp("queues_left", 0, txq.size() + rxq.size());
      end_of_test();
   end
endmodule : testbench
